// ### common/rsfp_pkg.sv
package rsfp_pkg;
  localparam int NR = 2;
  localparam int NP = 4;
  localparam int NSLOT = 8;
  localparam int CLK_MHZ = 200;
  localparam int INIT_US = 200;
  localparam int INIT_CYC = INIT_US * CLK_MHZ;
  localparam int CHK_CYC = 16;
  localparam int LS_HALF = 32;
  localparam int RETRY_CYC = 4096;
  // register byte offsets
  localparam logic [5:0] A_PAGE = 6'h00;
  localparam logic [5:0] A_CTRL = 6'h04;
  localparam logic [5:0] A_DLY  = 6'h08;
  localparam logic [5:0] A_RAMP = 6'h0C;
  localparam logic [5:0] A_VTH  = 6'h10;
  localparam logic [5:0] A_OCT  = 6'h14;
  localparam logic [5:0] A_OCP  = 6'h18;
  localparam logic [5:0] A_FILT = 6'h1C;
  localparam logic [5:0] A_TMP  = 6'h20;
  localparam logic [5:0] A_MAP  = 6'h24;
  localparam logic [5:0] A_STAT = 6'h28;
  localparam logic [5:0] A_BOOT = 6'h2C;
  localparam logic [5:0] A_SAVE = 6'h30;
  // fault vector bit positions
  localparam int F_OV  = 0;
  localparam int F_UV  = 1;
  localparam int F_OCF = 2;
  localparam int F_OCS = 3;
  localparam int F_OCP = 4;
  localparam int F_STG = 5;
  localparam int F_OT  = 6;
  localparam int F_WRN = 7;
  localparam logic [7:0]  PG_FORCE = 8'h1F;
  localparam logic [11:0] FS_POS   = 12'h7FF;
  localparam logic [11:0] FS_NEG   = 12'h800;
  localparam int STRAP_OHMS [NSLOT] = '{6800, 1800, 2200, 2700, 3300, 3900, 4700, 5600};

  typedef enum logic [5:0] {
    R_OFF = 6'h01, R_INIT = 6'h02, R_RAMP = 6'h04,
    R_ON = 6'h08, R_DOWN = 6'h10, R_FLT = 6'h20
  } rsfp_rail_e;

  typedef enum logic [4:0] {
    B_POR = 5'h01, B_CHK = 5'h02, B_LOAD = 5'h04, B_LOCK = 5'h08, B_RDY = 5'h10
  } rsfp_boot_e;

  typedef struct packed {
    logic [11:0] vout;
    logic [9:0]  temp;
    logic        sns_open;
  } rsfp_sense_s;

  typedef struct packed {
    logic        on;
    logic [6:0]  fen;
    logic [6:0]  rty;
    logic [15:0] dly;
    logic [15:0] rup;
    logic [15:0] rdn;
    logic [11:0] ov;
    logic [11:0] uv;
    logic [11:0] ocf;
    logic [11:0] ocs;
    logic [11:0] pk;
    logic [7:0]  pkn;
    logic        pkf;
    logic [3:0]  fsh;
    logic [3:0]  ssh;
    logic [7:0]  frs;
    logic [7:0]  srs;
    logic [9:0]  twn;
    logic [9:0]  tft;
    logic [7:0]  pgm;
    logic [7:0]  twm;
  } rsfp_cfg_s;

  localparam rsfp_cfg_s CFG_RST = '{on: 1'b0, fen: 7'h7F, rty: 7'h00, dly: 16'h0000,
    rup: 16'h0400, rdn: 16'h0400, ov: 12'hE00, uv: 12'h200, ocf: 12'h600,
    ocs: 12'h400, pk: 12'h700, pkn: 8'h10, pkf: 1'b0, fsh: 4'h1, ssh: 4'h4,
    frs: 8'h04, srs: 8'h40, twn: 10'h2A0, tft: 10'h300, pgm: 8'h7F, twm: 8'h80};
endpackage : rsfp_pkg

// ### rtl/rsfp_top.sv
// Contract
// - POR then check, load strapped set, read lockout, start telemetry
// - shutdown once supplies good; soft-start only on enable
// - shutdown rail holds phase outputs hi-z
// - delay from enable, then ramp; up and down ramps separate
// - 200 us init after enable before any ramp
// - zero ramp applies target at once
// - strap resistance decodes to id 0 to 7
// - load newest save with that id; eight saves total
// - per fault: enable bit and latch or retry
// - good only after soft-start, output in window
// - good fault map configurable; low on over-current, over/under-voltage
// - voltage checks: loop sample against bus thresholds
// - over-voltage: off, flag, alert, good low, pulse low side
// - under-voltage: off, flag, alert, good low
// - after voltage fault off until enable toggles, unless retry
// - open sense line counts as over-voltage
// - current total feeds fast and slow paths, no per-cycle action
// - phase past peak limit gets modulation inverted at once
// - peak limit indefinite or fault after counted consecutive cycles
// - enabled stage detector: full-scale sample shuts rail at once
// - thermal warning shows warning only, valid once enabled
// - warning and fault temperature thresholds; outputs map to either
// - page 0 selects rail 0, page 1 rail 1
//
// Design decisions made here: register access over Avalon-MM and the register offsets.
module rsfp_top
  import rsfp_pkg::*;
#(
  parameter int INIT_CYC_P = INIT_CYC
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rstn,
  input  wire logic                 ce,
  input  wire logic [5:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  input  wire logic [3:0]           avs_byteenable,
  output logic      [31:0]          avs_readdata,
  output logic                      avs_waitrequest,
  input  wire logic                 vcc_ok,
  input  wire logic [11:0]          vin_sample,
  input  wire logic [12:0]          strap_ohms,
  input  wire logic [NR-1:0]        rail_enable_input,
  input  wire rsfp_sense_s [NR-1:0] sns,
  input  wire logic [NP-1:0][11:0]  phase_cur,
  input  wire logic [NP-1:0]        pwm_in,
  output logic      [NP-1:0]        pwm_out,
  output logic      [NP-1:0]        pwm_oe,
  output logic      [NR-1:0]        low_side_switch,
  output logic      [NR-1:0]        rail_run,
  output logic      [NR-1:0]        rail_good_output_out,
  output logic      [NR-1:0]        rail_good_output_oe,
  output logic                      host_alert_output_out,
  output logic                      host_alert_output_oe,
  output logic                      thermal_warning_output_out,
  output logic                      thermal_warning_output_oe
);

  // nearest nominal strap value wins, tolerant of 1% parts
  function automatic logic [2:0] strap_id(input logic [12:0] r);
    int best;
    int d;
    best = 32'h7FFF;
    strap_id = 3'h0;
    for (int i = 0; i < NSLOT; i++) begin
      d = (int'(r) > STRAP_OHMS[i]) ? int'(r) - STRAP_OHMS[i] : STRAP_OHMS[i] - int'(r);
      if (d < best) begin
        best = d;
        strap_id = 3'(i);
      end
    end
  endfunction : strap_id

  function automatic logic [31:0] be_mrg(input logic [31:0] o, input logic [31:0] n, input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      if (be[i]) o[i*8 +: 8] = n[i*8 +: 8];
    end
    be_mrg = o;
  endfunction : be_mrg

  // register image of one rail's settings, shared by read and write
  function automatic logic [31:0] cfg_rd(input rsfp_cfg_s c, input logic [5:0] a);
    case (a)
      A_CTRL: cfg_rd = {1'b0, c.rty, 1'b0, c.fen, 15'h0000, c.on};
      A_DLY:  cfg_rd = {16'h0000, c.dly};
      A_RAMP: cfg_rd = {c.rdn, c.rup};
      A_VTH:  cfg_rd = {4'h0, c.uv, 4'h0, c.ov};
      A_OCT:  cfg_rd = {4'h0, c.ocs, 4'h0, c.ocf};
      A_OCP:  cfg_rd = {7'h00, c.pkf, c.pkn, 4'h0, c.pk};
      A_FILT: cfg_rd = {c.srs, c.frs, 8'h00, c.ssh, c.fsh};
      A_TMP:  cfg_rd = {6'h00, c.tft, 6'h00, c.twn};
      A_MAP:  cfg_rd = {16'h0000, c.twm, c.pgm};
      default: cfg_rd = 32'h0000_0000;
    endcase
  endfunction : cfg_rd

  function automatic logic [11:0] mag(input logic [11:0] x);
    mag = x[11] ? 12'(-x) : x;
  endfunction : mag

  // rail current filter: one-pole with shift coefficient
  function automatic logic signed [13:0] lpf(input logic signed [13:0] y,
                                            input logic signed [13:0] x, input logic [3:0] sh);
    lpf = y + ((x - y) >>> sh);
  endfunction : lpf

  logic             wait_q;
  logic [31:0]      rdata_q;
  logic             page_q;
  rsfp_cfg_s        cfg_q [NR];
  rsfp_cfg_s        cfg_d;
  logic [31:0]      wmrg;
  logic             wr_acc;
  rsfp_boot_e       boot_q;
  logic [4:0]       bcnt_q;
  logic [2:0]       cid_q;
  logic [31:0]      set_q;
  logic             loaded_q;
  logic [31:0]      nv_data [NSLOT];
  logic [2:0]       nv_id_q [NSLOT];
  logic [NSLOT-1:0] nv_used_q;
  logic [3:0]       saves_q;
  logic             refused_q;
  logic             nv_hit;
  logic [2:0]       nv_idx;
  logic [7:0]       flags_q [NR];
  rsfp_rail_e       st_q [NR];
  logic [NR-1:0]    tw_req;
  logic             od_q;

  assign wr_acc = avs_write && !wait_q;
  assign avs_waitrequest = wait_q;
  assign avs_readdata = rdata_q;

  // waitrequest low for one cycle after a request
  always_ff @(posedge sys_clk) begin
    if (!rstn) wait_q <= 1'b1;
    else if (ce) wait_q <= !(wait_q && (avs_read || avs_write));
  end

  // read data latched at request, stands while waitrequest low
  always_ff @(posedge sys_clk) begin
    if (!rstn) rdata_q <= 32'h0000_0000;
    else if (ce && wait_q && avs_read) begin
      case (avs_address)
        A_PAGE: rdata_q <= {31'h0000_0000, page_q};
        A_STAT: rdata_q <= {18'h00000, st_q[page_q], flags_q[page_q]};
        A_BOOT: rdata_q <= {14'h0000, refused_q, saves_q, boot_q, loaded_q, 4'h0, cid_q};
        A_SAVE: rdata_q <= set_q;
        default: rdata_q <= cfg_rd(cfg_q[page_q], avs_address); // unmapped reads zero
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) page_q <= 1'b0;
    else if (ce && wr_acc && avs_address == A_PAGE && avs_byteenable[0]) begin
      page_q <= avs_writedata[0];
    end
  end

  // unpack merged write into paged settings
  always_comb begin
    logic [15:0] pad;
    pad = 16'h0000;
    cfg_d = cfg_q[page_q];
    wmrg = be_mrg(cfg_rd(cfg_q[page_q], avs_address), avs_writedata, avs_byteenable);
    case (avs_address)
      A_CTRL: {pad[0], cfg_d.rty, pad[1], cfg_d.fen, pad[14:0], cfg_d.on} = wmrg;
      A_DLY:  {pad, cfg_d.dly} = wmrg;
      A_RAMP: {cfg_d.rdn, cfg_d.rup} = wmrg;
      A_VTH:  {pad[3:0], cfg_d.uv, pad[7:4], cfg_d.ov} = wmrg;
      A_OCT:  {pad[3:0], cfg_d.ocs, pad[7:4], cfg_d.ocf} = wmrg;
      A_OCP:  {pad[6:0], cfg_d.pkf, cfg_d.pkn, pad[10:7], cfg_d.pk} = wmrg;
      A_FILT: {cfg_d.srs, cfg_d.frs, pad[7:0], cfg_d.ssh, cfg_d.fsh} = wmrg;
      A_TMP:  {pad[5:0], cfg_d.tft, pad[11:6], cfg_d.twn} = wmrg;
      A_MAP:  {pad, cfg_d.twm, cfg_d.pgm} = wmrg;
      default: cfg_d = cfg_q[page_q];
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      for (int i = 0; i < NR; i++) cfg_q[i] <= CFG_RST;
    end else if (ce && wr_acc) begin
      cfg_q[page_q] <= cfg_d;
    end
  end

  // newest slot with the strap id wins
  always_comb begin
    nv_hit = 1'b0;
    nv_idx = 3'h0;
    for (int i = 0; i < NSLOT; i++) begin
      if (nv_used_q[i] && nv_id_q[i] == cid_q) begin
        nv_hit = 1'b1;
        nv_idx = 3'(i);
      end
    end
  end

  // setting store: eight saves in all, later ones refused
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      nv_used_q <= '0;
      saves_q <= 4'h0;
      refused_q <= 1'b0;
      for (int i = 0; i < NSLOT; i++) begin
        nv_data[i] <= 32'h0000_0000;
        nv_id_q[i] <= 3'h0;
      end
    end else if (ce && wr_acc && avs_address == A_SAVE && avs_byteenable == 4'hF) begin
      if (saves_q < 4'(NSLOT)) begin
        nv_data[saves_q[2:0]] <= avs_writedata;
        nv_id_q[saves_q[2:0]] <= cid_q;
        nv_used_q[saves_q[2:0]] <= 1'b1;
        saves_q <= saves_q + 4'h1;
      end else begin
        refused_q <= 1'b1;
      end
    end
  end

  // power-on flow; strap caught here, not by reset
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      boot_q <= B_POR;
      bcnt_q <= 5'h00;
      cid_q <= 3'h0;
      set_q <= 32'h0000_0000;
      loaded_q <= 1'b0;
    end else if (ce) begin
      case (boot_q)
        B_POR: if (vcc_ok) begin
          boot_q <= B_CHK;
          bcnt_q <= 5'h00;
          cid_q <= strap_id(strap_ohms);
        end
        B_CHK: begin
          bcnt_q <= bcnt_q + 5'h01;
          if (bcnt_q == 5'(CHK_CYC - 1)) boot_q <= B_LOAD;
        end
        B_LOAD: begin
          set_q <= nv_hit ? nv_data[nv_idx] : 32'h0000_0000;
          loaded_q <= nv_hit;
          boot_q <= B_LOCK;
        end
        B_LOCK: if (vin_sample >= set_q[11:0]) boot_q <= B_RDY;
        B_RDY: if (!vcc_ok) boot_q <= B_POR;
        default: boot_q <= B_POR;
      endcase
    end
  end

  for (genvar g = 0; g < NR; g++) begin : g_rail
    rsfp_cfg_s          c;
    rsfp_sense_s        s;
    logic [15:0]        icnt_q;
    logic [15:0]        dcnt_q;
    logic [15:0]        rcnt_q;
    logic [6:0]         cause_q;
    logic [6:0]         det;
    logic signed [13:0] tot;
    logic signed [13:0] fflt_q;
    logic signed [13:0] sflt_q;
    logic [7:0]         frc_q;
    logic [7:0]         src_q;
    logic [7:0]         pkc_q [2];
    logic [1:0]         pk;
    logic [1:0]         pkseen_q;
    logic [1:0]         pwmd_q;
    logic [5:0]         lsc_q;
    logic               ovd;
    logic               go;
    logic               act;
    logic               pkt;
    logic               good;

    assign c = cfg_q[g];
    assign s = sns[g];
    assign go = boot_q == B_RDY && rail_enable_input[g] && c.on;
    assign act = st_q[g] == R_RAMP || st_q[g] == R_ON;
    assign ovd = s.vout > c.ov || s.sns_open;
    assign tot = 14'($signed(phase_cur[2*g])) + 14'($signed(phase_cur[2*g+1]));

    always_comb begin
      for (int j = 0; j < 2; j++) pk[j] = mag(phase_cur[2*g+j]) >= c.pk;
      pkt = c.pkf && (pkc_q[0] >= c.pkn || pkc_q[1] >= c.pkn);
      det[F_OV] = ovd;
      det[F_UV] = st_q[g] == R_ON && s.vout < c.uv;
      det[F_OCF] = fflt_q > $signed({2'b00, c.ocf}) && frc_q >= c.frs;
      det[F_OCS] = sflt_q > $signed({2'b00, c.ocs}) && src_q >= c.srs;
      det[F_OCP] = pkt;
      det[F_STG] = phase_cur[2*g] == FS_POS || phase_cur[2*g] == FS_NEG
                || phase_cur[2*g+1] == FS_POS || phase_cur[2*g+1] == FS_NEG;
      det[F_OT] = s.temp >= c.tft;
      det = det & c.fen;
      good = st_q[g] == R_ON && s.vout >= c.uv && !ovd
          && !(|({s.temp >= c.twn, det} & (c.pgm | PG_FORCE)));
    end

    // two filtered total-current paths; they only count, never touch modulation
    always_ff @(posedge sys_clk) begin
      if (!rstn) begin
        fflt_q <= 14'sh0000;
        sflt_q <= 14'sh0000;
        frc_q <= 8'h00;
        src_q <= 8'h00;
      end else if (ce) begin
        fflt_q <= lpf(fflt_q, tot, c.fsh);
        sflt_q <= lpf(sflt_q, tot, c.ssh);
        frc_q <= fflt_q <= $signed({2'b00, c.ocf}) ? 8'h00 : (frc_q == c.frs ? frc_q : frc_q + 8'h01);
        src_q <= sflt_q <= $signed({2'b00, c.ocs}) ? 8'h00 : (src_q == c.srs ? src_q : src_q + 8'h01);
      end
    end

    // consecutive limited cycles, counted per pwm period
    always_ff @(posedge sys_clk) begin
      if (!rstn) begin
        pkseen_q <= 2'b00;
        pwmd_q <= 2'b00;
        pkc_q[0] <= 8'h00;
        pkc_q[1] <= 8'h00;
      end else if (ce) begin
        pwmd_q <= pwm_in[2*g +: 2];
        for (int j = 0; j < 2; j++) begin
          if (pwm_in[2*g+j] && !pwmd_q[j]) begin
            pkseen_q[j] <= pk[j];
            pkc_q[j] <= pkseen_q[j] ? (pkc_q[j] == 8'hFF ? pkc_q[j] : pkc_q[j] + 8'h01) : 8'h00;
          end else if (pk[j]) begin
            pkseen_q[j] <= 1'b1;
          end
        end
      end
    end

    // rail sequencer; faults here never reach the other rail
    always_ff @(posedge sys_clk) begin
      if (!rstn) begin
        st_q[g] <= R_OFF;
        icnt_q <= 16'h0000;
        dcnt_q <= 16'h0000;
        rcnt_q <= 16'h0000;
        cause_q <= 7'h00;
      end else if (ce) begin
        case (st_q[g])
          R_OFF: if (go) begin
            st_q[g] <= R_INIT;
            icnt_q <= 16'h0000;
            dcnt_q <= 16'h0000;
          end
          R_INIT: begin
            if (icnt_q != 16'(INIT_CYC_P)) icnt_q <= icnt_q + 16'h0001;
            if (dcnt_q != c.dly) dcnt_q <= dcnt_q + 16'h0001;
            rcnt_q <= 16'h0000;
            if (!go) st_q[g] <= R_OFF;
            else if (|(det & (7'h01 << F_OT | 7'h01 << F_STG))) begin
              st_q[g] <= R_FLT;
              cause_q <= det;
            end else if (icnt_q >= 16'(INIT_CYC_P - 1) && dcnt_q >= c.dly) begin
              st_q[g] <= c.rup == 16'h0000 ? R_ON : R_RAMP;
            end
          end
          R_RAMP, R_ON: begin
            rcnt_q <= rcnt_q + 16'h0001;
            if (|det) begin
              st_q[g] <= R_FLT;
              cause_q <= det;
              rcnt_q <= 16'h0000;
            end else if (!go) begin
              st_q[g] <= R_DOWN;
              rcnt_q <= 16'h0000;
            end else if (st_q[g] == R_RAMP && rcnt_q >= c.rup - 16'h0001) begin
              st_q[g] <= R_ON;
            end
          end
          R_DOWN: begin
            rcnt_q <= rcnt_q + 16'h0001;
            if (rcnt_q >= c.rdn) st_q[g] <= R_OFF;
          end
          R_FLT: begin
            if (rcnt_q != 16'(RETRY_CYC)) rcnt_q <= rcnt_q + 16'h0001;
            // latched causes wait for enable low, retry causes for the back-off
            if (!go) st_q[g] <= R_OFF;
            else if ((cause_q & ~c.rty) == 7'h00 && rcnt_q == 16'(RETRY_CYC) && !ovd) begin
              st_q[g] <= R_OFF;
            end
          end
          default: st_q[g] <= R_OFF;
        endcase
      end
    end

    // sticky flags: write one to clear, a new event in the same cycle wins
    always_ff @(posedge sys_clk) begin
      if (!rstn) flags_q[g] <= 8'h00;
      else if (ce) begin
        flags_q[g] <= (flags_q[g] & ~((wr_acc && avs_address == A_STAT && page_q == 1'(g) && avs_byteenable[0])
                      ? avs_writedata[7:0] : 8'h00))
                      | {act && s.temp >= c.twn, act ? det : 7'h00};
      end
    end

    // pins: hi-z in shutdown, inverted phase on limit, low-side pulses on overvoltage
    always_ff @(posedge sys_clk) begin
      if (!rstn) begin
        pwm_out[2*g +: 2] <= 2'b00;
        pwm_oe[2*g +: 2] <= 2'b00;
        low_side_switch[g] <= 1'b0;
        lsc_q <= 6'h00;
        rail_run[g] <= 1'b0;
        rail_good_output_oe[g] <= 1'b1;
      end else if (ce) begin
        pwm_oe[2*g +: 2] <= {2{act && !(|det)}};
        pwm_out[2*g +: 2] <= pwm_in[2*g +: 2] ^ pk;
        lsc_q <= lsc_q == 6'(LS_HALF - 1) ? 6'h00 : lsc_q + 6'h01;
        if (st_q[g] == R_FLT && cause_q[F_OV] && ovd) begin
          if (lsc_q == 6'(LS_HALF - 1)) low_side_switch[g] <= !low_side_switch[g];
        end else begin
          low_side_switch[g] <= 1'b0;
        end
        rail_run[g] <= act && !(|det);
        rail_good_output_oe[g] <= !good;
      end
    end

    assign tw_req[g] = st_q[g] != R_OFF && (|({s.temp >= c.twn, s.temp >= c.tft} & {c.twm[F_WRN], c.twm[F_OT]}));
  end

  // shared open-drain pins; the driven level is always low
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      od_q <= 1'b0;
      host_alert_output_oe <= 1'b0;
      thermal_warning_output_oe <= 1'b0;
    end else if (ce) begin
      od_q <= 1'b0;
      host_alert_output_oe <= |(flags_q[0][6:0] | flags_q[1][6:0]);
      thermal_warning_output_oe <= |tw_req;
    end
  end

  assign host_alert_output_out = od_q;
  assign thermal_warning_output_out = od_q;
  assign rail_good_output_out = {NR{od_q}};

endmodule : rsfp_top

// ### sim/rsfp_chk.sv
module rsfp_chk
  import rsfp_pkg::*;
#(
  parameter int INIT_CYC_P = 50
) (
  input wire logic                sys_clk,
  input wire logic                rstn,
  input wire logic                avs_read,
  input wire logic                avs_write,
  input wire logic                avs_waitrequest,
  input wire logic [NR-1:0]       rail_enable_input,
  input wire logic [NP-1:0][11:0] phase_cur,
  input wire logic [NP-1:0]       pwm_in,
  input wire logic [NP-1:0]       pwm_out,
  input wire logic [NP-1:0]       pwm_oe,
  input wire logic [NR-1:0]       low_side_switch,
  input wire logic [NR-1:0]       rail_run,
  input wire logic [NR-1:0]       rail_good_output_oe,
  input wire logic                host_alert_output_oe
);
  logic [15:0] ecnt_q;
  logic [11:0] ocnt_q;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // cycles since enable, saturating
  always_ff @(posedge sys_clk) begin
    if (!rstn || !rail_enable_input[0]) ecnt_q <= 16'h0000;
    else if (ecnt_q != 16'hFFFF) ecnt_q <= ecnt_q + 16'h0001;
  end
  // cycles with enable low
  always_ff @(posedge sys_clk) begin
    if (!rstn || rail_enable_input[0]) ocnt_q <= 12'h000;
    else if (ocnt_q != 12'hFFF) ocnt_q <= ocnt_q + 12'h001;
  end
  AST_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  AST_ONE_CYC: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  AST_INIT_WAIT: assert property ($rose(rail_run[0]) |-> ecnt_q >= 16'(INIT_CYC_P - 2))
    else $error("ramp before init time");
  AST_EN_OFF: assert property (!rail_enable_input[0] [*4] |-> !rail_run[0])
    else $error("rail runs without enable");
  AST_HIZ: assert property (ocnt_q > 12'h7D0 |-> pwm_oe[1:0] == 2'b00)
    else $error("shutdown rail drives phases");
  AST_PEAK_NEG: assert property (pwm_oe[0] && $past(phase_cur[0]) > 12'h800 && $past(phase_cur[0]) < 12'h8F0
    |-> pwm_out[0] != $past(pwm_in[0]))
    else $error("negative peak not inverted");
  AST_PEAK_POS: assert property (pwm_oe[1] && $past(phase_cur[1]) > 12'h710 && $past(phase_cur[1]) < 12'h7FF
    |-> pwm_out[1] != $past(pwm_in[1]))
    else $error("positive peak not inverted");
  AST_PASS: assert property (pwm_oe[0] && $past(phase_cur[0]) < 12'h100 |-> pwm_out[0] == $past(pwm_in[0]))
    else $error("phase output altered below limit");
  AST_LS: assert property (low_side_switch[0] |-> !rail_run[0] && host_alert_output_oe)
    else $error("low side pulse outside fault");
  AST_GOOD: assert property (!rail_good_output_oe[0] |-> rail_run[0] || $past(rail_run[0]))
    else $error("good while rail not running");
endmodule : rsfp_chk

bind rsfp_top rsfp_chk #(.INIT_CYC_P(INIT_CYC_P)) u_rsfp_chk (.sys_clk, .rstn, .avs_read, .avs_write,
  .avs_waitrequest, .rail_enable_input, .phase_cur, .pwm_in, .pwm_out, .pwm_oe, .low_side_switch, .rail_run,
  .rail_good_output_oe, .host_alert_output_oe);

// ### sim/rsfp_stage.sv
module rsfp_stage
  import rsfp_pkg::*;
(
  input  wire logic                sys_clk,
  input  wire logic [NP-1:0]       pwm_oe,
  input  wire logic                ls,
  input  wire logic [11:0]         vset,
  input  wire logic                sopen,
  input  wire logic [9:0]          tset,
  input  wire logic [NP-1:0][11:0] icur,
  output rsfp_sense_s [NR-1:0]     sns,
  output logic [NP-1:0][11:0]      phase_cur
);
  logic [11:0] v_q = 12'h800;
  logic [11:0] vs_q = 12'h800;
  logic        ls_q = 1'b0;
  // each low-side pulse bleeds the output
  always_ff @(posedge sys_clk) begin
    vs_q <= vset;
    ls_q <= ls;
    if (vset != vs_q) v_q <= vset;
    else if (ls && !ls_q) v_q <= v_q - 12'h040;
  end
  // rail 1 quiet; undriven stage carries no current
  assign sns[0] = '{vout: v_q, temp: tset, sns_open: sopen};
  assign sns[1] = '{vout: 12'h800, temp: 10'h100, sns_open: 1'b0};
  always_comb for (int p = 0; p < NP; p++) phase_cur[p] = pwm_oe[p] ? icur[p] : 12'h000;
endmodule : rsfp_stage

// ### sim/tb.sv
module tb
  import rsfp_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [5:0] a; logic [31:0] r; logic [31:0] m;} rsfp_row_s;
  typedef struct packed {logic [11:0] v; logic o; logic [23:0] c; logic [9:0] t; logic [2:0] b;} rsfp_flt_s;
  localparam rsfp_row_s RW [10] = '{'{A_CTRL, 32'h007F0000, 32'h7F7F0001}, '{A_DLY, 32'h0, 32'h0000FFFF},
    '{A_RAMP, 32'h04000400, 32'hFFFFFFFF}, '{A_VTH, 32'h02000E00, 32'h0FFF0FFF},
    '{A_OCT, 32'h04000600, 32'h0FFF0FFF}, '{A_OCP, 32'h00100700, 32'h01FF0FFF},
    '{A_FILT, 32'h40040041, 32'hFFFF00FF}, '{A_TMP, 32'h030002A0, 32'h03FF03FF},
    '{A_MAP, 32'h0000807F, 32'h0000FFFF}, '{6'h3C, 32'h0, 32'h0}};
  localparam rsfp_flt_s FL [6] = '{'{12'hF00, 1'b0, 24'h0, 10'h100, 3'h0}, '{12'h800, 1'b1, 24'h0, 10'h100, 3'h0},
    '{12'h100, 1'b0, 24'h0, 10'h100, 3'h1}, '{12'h800, 1'b0, 24'h7F0810, 10'h100, 3'h4},
    '{12'h800, 1'b0, 24'h0007FF, 10'h100, 3'h5}, '{12'h800, 1'b0, 24'h0, 10'h310, 3'h6}};
  logic sys_clk = 1'b0, rstn = 1'b0, vcc_ok = 1'b0, avs_read = 1'b0, avs_write = 1'b0, sopen = 1'b0;
  logic avs_waitrequest, host_alert_output_oe, thermal_warning_output_oe;
  logic [5:0] avs_address = 6'h00;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic [12:0] strap_ohms = 13'h0000;
  logic [11:0] vset = 12'h800;
  logic [9:0] tset = 10'h100;
  logic [NR-1:0] rail_enable_input = 2'h0, low_side_switch, rail_run, rail_good_output_oe;
  logic [NP-1:0] pwm_in = 4'h0, pwm_out, pwm_oe;
  logic [NP-1:0][11:0] phase_cur, icur = '0;
  rsfp_sense_s [NR-1:0] sns;
  int error_cnt = 0, checks = 0, n;

  rsfp_top #(.INIT_CYC_P(50)) u_rsfp_top (.sys_clk, .rstn, .ce(1'b1), .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .vcc_ok, .vin_sample(12'h100),
    .strap_ohms, .rail_enable_input, .sns, .phase_cur, .pwm_in, .pwm_out, .pwm_oe, .low_side_switch,
    .rail_run, .rail_good_output_out(), .rail_good_output_oe, .host_alert_output_out(), .host_alert_output_oe,
    .thermal_warning_output_out(), .thermal_warning_output_oe);
  rsfp_stage u_rsfp_stage (.sys_clk, .pwm_oe, .ls(low_side_switch[0]), .vset, .sopen, .tset, .icur, .sns,
    .phase_cur);

  // clock; counting modulator so inversion shows
  initial forever #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) pwm_in <= pwm_in + 4'h1;

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : tick
  // one bus access, launched and closed at rising edges
  task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge sys_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    rd = avs_readdata;
    if (avs_waitrequest !== 1'b0) error_cnt++;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : acc
  task automatic rst(input int s);
    strap_ohms <= 13'(STRAP_OHMS[s]);
    rstn <= 1'b0;
    vcc_ok <= 1'b0;
    tick(10);
    rstn <= 1'b1;
    acc(1'b0, A_BOOT, 32'h0);
    chk("boot_por", rd[12:8], B_POR);
    vcc_ok <= 1'b1;
    tick(24);
    acc(1'b0, A_BOOT, 32'h0);
    chk("boot_id", {rd[12:8], rd[2:0]}, {B_RDY, 3'(s)});
  endtask : rst
  task automatic go();
    n = 0;
    rail_enable_input[0] <= 1'b1;
    while (rail_run[0] !== 1'b1 && n < 500) begin
      tick(1);
      n++;
    end
  endtask : go
  task automatic results();
    if (error_cnt == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results

  // hang guard
  initial begin
    #150us;
    error_cnt++;
    results();
  end

  initial begin
    for (int s = 0; s < NSLOT; s++) rst(s);
    foreach (RW[i]) begin
      acc(1'b1, A_PAGE, 32'h1);
      acc(1'b1, RW[i].a, 32'hFFFFFFFF);
      acc(1'b0, RW[i].a, 32'h0);
      chk("reg_rw", rd, RW[i].m);
      acc(1'b1, A_PAGE, 32'h0);
      acc(1'b0, RW[i].a, 32'h0);
      chk("reg_rst", rd, RW[i].r);
    end
    // partial save ignored; ninth refused
    avs_byteenable <= 4'h3;
    acc(1'b1, A_SAVE, 32'h0);
    avs_byteenable <= 4'hF;
    acc(1'b0, A_BOOT, 32'h0);
    chk("save_be", rd[17:13], 5'h00);
    repeat (9) acc(1'b1, A_SAVE, 32'h0);
    acc(1'b0, A_BOOT, 32'h0);
    chk("save_cnt", rd[17:13], 5'h18);
    acc(1'b1, A_CTRL, 32'h007F0001);
    acc(1'b1, A_DLY, 32'h00000064);
    acc(1'b1, A_RAMP, 32'h000A0014);
    tick(2100);
    chk("hiz", pwm_oe, 4'h0);
    go();
    chk("delay", n >= 100 && n <= 106, 1);
    chk("good_ramp", rail_good_output_oe[0], 1);
    tick(30);
    chk("good_on", rail_good_output_oe[0], 0);
    chk("oe_on", pwm_oe, 4'h3);
    icur[1:0] <= 24'h7F0810;
    tick(40);
    chk("limit_run", rail_run[0], 1);
    icur <= '0;
    rail_enable_input[0] <= 1'b0;
    acc(1'b1, A_OCP, 32'h01040700);
    foreach (FL[i]) begin
      go();
      tick(30);
      {vset, sopen, icur[1:0], tset} <= {FL[i].v, FL[i].o, FL[i].c, FL[i].t};
      tick(20);
      chk("flt_run", rail_run[0], 0);
      chk("flt_pg", rail_good_output_oe[0], 1);
      chk("flt_alert", host_alert_output_oe, 1);
      acc(1'b0, A_STAT, 32'h0);
      chk("flt_flag", rd[FL[i].b], 1);
      if (i == 0) begin
        tick(5000);
        chk("latched", rail_run[0], 0);
      end
      {vset, sopen, icur[1:0], tset} <= {12'h800, 1'b0, 24'h0, 10'h100};
      rail_enable_input[0] <= 1'b0;
      tick(20);
      acc(1'b1, A_STAT, 32'hFF);
      tick(2);
      chk("alert_clr", host_alert_output_oe, 0);
    end
    go();
    tick(30);
    tset <= 10'h2B0;
    tick(20);
    chk("thermal_warning_output", thermal_warning_output_oe, 1);
    chk("warn_run", rail_run[0], 1);
    rail_enable_input[0] <= 1'b0;
    tick(100);
    chk("thermal_warning_output_off", thermal_warning_output_oe, 0);
    results();
  end
endmodule : tb
